// file: uri_pkg.sv
// What this block does
// - Control bit 0 enables the serial block; when it is clear the transmit and receive pins go back to general IO.
// - All bit timing comes from the block clock and the baud setting held in the control register.
// - Control bit 4 divides the selected baud rate by eight when set, and leaves it undivided when clear.
// - Control bits 3 to 1 pick 115.2 down to 7.2 kBaud, or 14.4 down to 0.9 kBaud with the prescaler.
// - The status register is read-only, bits 15 to 2 read zero, and the two buffer flags sit in bits 1 and 0.
// - Status bit 1 shows a received byte is waiting and clears itself when software reads the data register.
// - A full receive buffer raises interrupt five, gated by the serial bit of the interrupt enable register.
// - Status bit 0 sets as soon as software writes a byte to the data register with byte lane 0 on while control bit 0 is set, showing the transmitter busy.
// - Status bit 0 clears once the written byte has been sent completely, so a new byte may be written.
// - An empty transmit buffer raises interrupt four while control bit 0 is set, gated by the serial bit of the interrupt enable register.
// - A write to the data register with byte lane 0 on, while control bit 0 is set, loads its low byte into the transmitter and starts sending it.
// - Reading the data register returns the latest received byte in the low byte, with the upper byte zero.
`default_nettype none
package uri_pkg;

   // apb decode: every printed offset is a word index, byte address is index times four
   localparam int unsigned APB_ADDR_W = 18;
   localparam int unsigned ADDR_LSB   = 2;
   localparam int unsigned IDX_W      = 16;
   localparam logic [15:0] IDX_CONTROL    = 16'hC0E0;
   localparam logic [15:0] IDX_STATUS     = 16'hC0E2;
   localparam logic [15:0] IDX_DATA       = 16'hC0E4;
   localparam logic [15:0] IDX_IRQ_ENABLE = 16'hC00E;
   localparam logic [15:0] IDX_EVT_STATUS = 16'hC110;
   localparam logic [15:0] IDX_EVT_MASK   = 16'hC112;

   // reset values and writable masks
   localparam logic [15:0] CONTROL_RESET  = 16'h0007;
   localparam logic [15:0] CONTROL_WMASK  = 16'h001F;
   localparam logic [15:0] IRQ_EN_RESET   = 16'h0000;
   localparam int unsigned IRQ_EN_SERIAL_BIT = 4;

   // timing
   localparam int unsigned CLK_HZ_DEFAULT = 125_000_000;
   localparam int unsigned DIV_W          = 24;
   localparam int unsigned PRESCALE_SHIFT = 3;
   localparam int unsigned BAUD_RATE [8]  = '{115200, 57600, 38400, 28800, 19200, 14400, 9600, 7200};
   localparam int unsigned BAUD_CODES     = 8;
   localparam logic [2:0]  LAST_DATA_BIT  = 3'h7;

   typedef struct packed {
      logic [10:0] rsvd;
      logic        prescale;
      logic [2:0]  baud;
      logic        enable;
   } uri_ctrl_type;

   // shared by the buffer flags and the sticky event bits
   typedef struct packed {
      logic rx_full;
      logic tx_full;
   } uri_flags_type;

   typedef enum logic [1:0] {
      URI_TX_IDLE  = 2'b00,
      URI_TX_START = 2'b01,
      URI_TX_DATA  = 2'b10,
      URI_TX_STOP  = 2'b11
   } uri_tx_state_type;

   typedef enum logic [1:0] {
      URI_RX_IDLE  = 2'b00,
      URI_RX_START = 2'b01,
      URI_RX_DATA  = 2'b10,
      URI_RX_STOP  = 2'b11
   } uri_rx_state_type;

   // byte-lane merge for the 16-bit registers
   function automatic logic [15:0] uri_merge_lanes(input logic [15:0] old_v, input logic [31:0] wdata,
                                                   input logic [3:0] strb);
      logic [15:0] v;
      v = old_v;
      if (strb[0]) begin
         v[7:0] = wdata[7:0];
      end
      if (strb[1]) begin
         v[15:8] = wdata[15:8];
      end
      return v;
   endfunction : uri_merge_lanes

endpackage : uri_pkg
`default_nettype wire

// file: uri_serdes.sv
`timescale 1ns/1ps
`default_nettype none
module uri_tx (
   input  wire logic                     pclk,     // block clock
   input  wire logic                     presetn,  // async reset, low
   input  wire logic                     enable,   // serial block on
   input  wire logic [uri_pkg::DIV_W-1:0] bit_div, // clocks per bit
   input  wire logic                     load,     // start a byte
   input  wire logic [7:0]               tx_byte,  // byte to send
   output logic                          txd,      // serial out
   output logic                          done      // byte finished, pulse
);
   uri_pkg::uri_tx_state_type state_reg, state_next;
   logic [uri_pkg::DIV_W-1:0] cnt_reg, cnt_next;
   logic [2:0]                bit_reg, bit_next;
   logic [7:0]                shift_reg, shift_next;
   logic                      txd_reg, txd_next;
   logic                      bit_end;

   assign bit_end = (cnt_reg == bit_div - uri_pkg::DIV_W'(1));
   assign txd     = txd_reg;

   // framing sequencer; a fresh load restarts even mid-byte
   always_comb begin
      state_next = state_reg;
      cnt_next   = bit_end ? '0 : cnt_reg + uri_pkg::DIV_W'(1);
      bit_next   = bit_reg;
      shift_next = shift_reg;
      txd_next   = txd_reg;
      done       = 1'b0;
      case (state_reg)
         uri_pkg::URI_TX_IDLE: begin
            cnt_next = '0;
            txd_next = 1'b1;
         end
         uri_pkg::URI_TX_START: begin
            if (bit_end) begin
               state_next = uri_pkg::URI_TX_DATA;
               bit_next   = '0;
               txd_next   = shift_reg[0];
            end
         end
         uri_pkg::URI_TX_DATA: begin
            if (bit_end) begin
               if (bit_reg == uri_pkg::LAST_DATA_BIT) begin
                  state_next = uri_pkg::URI_TX_STOP;
                  txd_next   = 1'b1;
               end else begin
                  bit_next   = bit_reg + 3'h1;
                  shift_next = {1'b0, shift_reg[7:1]};
                  txd_next   = shift_reg[1];
               end
            end
         end
         uri_pkg::URI_TX_STOP: begin
            if (bit_end) begin
               state_next = uri_pkg::URI_TX_IDLE;
               done       = 1'b1;
            end
         end
         default: begin
            state_next = uri_pkg::URI_TX_IDLE;
         end
      endcase
      if (load) begin
         state_next = uri_pkg::URI_TX_START;
         cnt_next   = '0;
         shift_next = tx_byte;
         txd_next   = 1'b0;
         done       = 1'b0;
      end
      if (!enable) begin
         state_next = uri_pkg::URI_TX_IDLE;
         txd_next   = 1'b1;
         done       = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= uri_pkg::URI_TX_IDLE;
         cnt_reg   <= '0;
         bit_reg   <= '0;
         shift_reg <= '0;
         txd_reg   <= 1'b1;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         bit_reg   <= bit_next;
         shift_reg <= shift_next;
         txd_reg   <= txd_next;
      end
   end

   property p_start_bit_low;
      @(posedge pclk) disable iff (!presetn) (load && enable) |=> (!txd && state_reg == uri_pkg::URI_TX_START);
   endproperty
   a_start_bit_low: assert property (p_start_bit_low) else $error("start bit not driven after load");

endmodule : uri_tx

module uri_rx (
   input  wire logic                     pclk,     // block clock
   input  wire logic                     presetn,  // async reset, low
   input  wire logic                     enable,   // serial block on
   input  wire logic [uri_pkg::DIV_W-1:0] bit_div, // clocks per bit
   input  wire logic                     rxd,      // serial in, idles high
   output logic                          valid,    // byte ready, pulse
   output logic [7:0]                    rx_byte   // received byte
);
   uri_pkg::uri_rx_state_type state_reg, state_next;
   logic [uri_pkg::DIV_W-1:0] cnt_reg, cnt_next;
   logic [2:0]                bit_reg, bit_next;
   logic [7:0]                shift_reg, shift_next;
   logic                      bit_end, half_end;

   assign bit_end  = (cnt_reg == bit_div - uri_pkg::DIV_W'(1));
   assign half_end = (cnt_reg == (bit_div >> 1));
   assign rx_byte  = shift_reg;

   // start found at mid-bit, then one sample per bit period; bad stop drops the byte
   always_comb begin
      state_next = state_reg;
      cnt_next   = bit_end ? '0 : cnt_reg + uri_pkg::DIV_W'(1);
      bit_next   = bit_reg;
      shift_next = shift_reg;
      valid      = 1'b0;
      case (state_reg)
         uri_pkg::URI_RX_IDLE: begin
            cnt_next = '0;
            if (!rxd) begin
               state_next = uri_pkg::URI_RX_START;
            end
         end
         uri_pkg::URI_RX_START: begin
            if (half_end) begin
               cnt_next   = '0;
               bit_next   = '0;
               state_next = rxd ? uri_pkg::URI_RX_IDLE : uri_pkg::URI_RX_DATA; // glitch filter
            end
         end
         uri_pkg::URI_RX_DATA: begin
            if (bit_end) begin
               shift_next = {rxd, shift_reg[7:1]};
               bit_next   = bit_reg + 3'h1;
               if (bit_reg == uri_pkg::LAST_DATA_BIT) begin
                  state_next = uri_pkg::URI_RX_STOP;
               end
            end
         end
         uri_pkg::URI_RX_STOP: begin
            if (bit_end) begin
               state_next = uri_pkg::URI_RX_IDLE;
               valid      = rxd;
            end
         end
         default: begin
            state_next = uri_pkg::URI_RX_IDLE;
         end
      endcase
      if (!enable) begin
         state_next = uri_pkg::URI_RX_IDLE;
         valid      = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= uri_pkg::URI_RX_IDLE;
         cnt_reg   <= '0;
         bit_reg   <= '0;
         shift_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         bit_reg   <= bit_next;
         shift_reg <= shift_next;
      end
   end

endmodule : uri_rx
`default_nettype wire

// file: uri_top.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module uri_top #(
   parameter int unsigned CLK_HZ = uri_pkg::CLK_HZ_DEFAULT // block clock rate, sets bit timing
) (
   input  wire logic                          pclk,                 // apb clock
   input  wire logic                          presetn,              // async reset, low
   input  wire logic                          psel,                 // apb select
   input  wire logic                          penable,              // apb access phase
   input  wire logic                          pwrite,               // apb direction
   input  wire logic [uri_pkg::APB_ADDR_W-1:0] paddr,               // apb byte address
   input  wire logic [31:0]                   pwdata,               // apb write data
   input  wire logic [3:0]                    pstrb,                // apb byte strobes
   output logic [31:0]                        prdata,               // apb read data
   output logic                               pready,               // apb ready
   output logic                               pslverr,              // apb error
   output logic                               irq,                  // masked sticky events
   output logic                               irq_rx_full,          // interrupt five
   output logic                               irq_tx_empty,         // interrupt four
   input  wire logic                          gpio_28_value,        // general io drive value
   input  wire logic                          gpio_28_drive,        // general io drive enable
   output logic                               general_io_pin_28_out, // transmit pin value
   output logic                               general_io_pin_28_oe,  // transmit pin enable
   input  wire logic                          general_io_pin_27_in  // receive pin
);
   uri_pkg::uri_ctrl_type   ctrl_reg, ctrl_next;
   uri_pkg::uri_flags_type  flags_reg, flags_next;
   uri_pkg::uri_flags_type  evt_reg, evt_next;
   uri_pkg::uri_flags_type  mask_reg, mask_next;
   logic [15:0]             irq_en_reg, irq_en_next;
   logic [7:0]              rx_data_reg, rx_data_next;
   logic [31:0]             prdata_reg, prdata_next;
   logic                    pslverr_reg, pslverr_next;

   logic [uri_pkg::IDX_W-1:0] idx;
   logic                      hit_ctrl, hit_stat, hit_data, hit_ien, hit_evt, hit_mask, hit_any;
   logic                      setup, wr, rd, tx_load, tx_done, rx_valid, txd, rxd_gated, serial_ien;
   logic [7:0]                rx_byte;
   logic [15:0]               rd_mux;
   logic [uri_pkg::DIV_W-1:0] div_table [uri_pkg::BAUD_CODES];
   logic [uri_pkg::DIV_W-1:0] bit_div;

   // address decode on the word index
   assign idx      = paddr[uri_pkg::IDX_W+uri_pkg::ADDR_LSB-1:uri_pkg::ADDR_LSB];
   assign hit_ctrl = (idx == uri_pkg::IDX_CONTROL);
   assign hit_stat = (idx == uri_pkg::IDX_STATUS);
   assign hit_data = (idx == uri_pkg::IDX_DATA);
   assign hit_ien  = (idx == uri_pkg::IDX_IRQ_ENABLE);
   assign hit_evt  = (idx == uri_pkg::IDX_EVT_STATUS);
   assign hit_mask = (idx == uri_pkg::IDX_EVT_MASK);
   assign hit_any  = hit_ctrl | hit_stat | hit_data | hit_ien | hit_evt | hit_mask;

   // zero wait states: read data is captured in setup so it comes from a flop
   assign setup   = psel & ~penable;
   assign wr      = psel & penable & pwrite;
   assign rd      = psel & penable & ~pwrite;
   assign pready  = 1'b1;
   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg;

   // one divisor per baud code, built at elaboration to avoid a runtime divider
   for (genvar g = 0; g < uri_pkg::BAUD_CODES; g++) begin : g_baud
      assign div_table[g] = uri_pkg::DIV_W'(CLK_HZ / uri_pkg::BAUD_RATE[g]);
   end

   // prescaler stretches every bit eight times
   assign bit_div = ctrl_reg.prescale ? uri_pkg::DIV_W'(div_table[ctrl_reg.baud] << uri_pkg::PRESCALE_SHIFT)
                                      : div_table[ctrl_reg.baud];

   // low byte only; a write with lane 0 off does not start a byte
   assign tx_load = wr & hit_data & pstrb[0] & ctrl_reg.enable;

   // receiver sees an idle line while the pins belong to general io
   assign rxd_gated = ctrl_reg.enable ? general_io_pin_27_in : 1'b1;

   uri_tx u_tx (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (ctrl_reg.enable),
      .bit_div (bit_div),
      .load    (tx_load),
      .tx_byte (pwdata[7:0]),
      .txd     (txd),
      .done    (tx_done)
   );

   uri_rx u_rx (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (ctrl_reg.enable),
      .bit_div (bit_div),
      .rxd     (rxd_gated),
      .valid   (rx_valid),
      .rx_byte (rx_byte)
   );

   // pin ownership follows the enable bit
   assign general_io_pin_28_out = ctrl_reg.enable ? txd : gpio_28_value;
   assign general_io_pin_28_oe  = ctrl_reg.enable ? 1'b1 : gpio_28_drive;

   // interrupt lines
   assign serial_ien   = irq_en_reg[uri_pkg::IRQ_EN_SERIAL_BIT];
   assign irq_rx_full  = serial_ien & flags_reg.rx_full;
   assign irq_tx_empty = serial_ien & ctrl_reg.enable & ~flags_reg.tx_full;
   assign irq          = |(evt_reg & mask_reg);

   // read mux; reserved bits read zero
   always_comb begin
      rd_mux = '0;
      if (hit_ctrl) begin
         rd_mux = ctrl_reg;
      end else if (hit_stat) begin
         rd_mux = {14'h0000, flags_reg};
      end else if (hit_data) begin
         rd_mux = {8'h00, rx_data_reg};
      end else if (hit_ien) begin
         rd_mux = irq_en_reg;
      end else if (hit_evt) begin
         rd_mux = {14'h0000, evt_reg};
      end else if (hit_mask) begin
         rd_mux = {14'h0000, mask_reg};
      end
   end

   // register file next state; in every flag a set beats a clear in the same cycle
   always_comb begin
      ctrl_next    = ctrl_reg;
      irq_en_next  = irq_en_reg;
      mask_next    = mask_reg;
      rx_data_next = rx_data_reg;
      flags_next   = flags_reg;
      evt_next     = evt_reg;
      prdata_next  = prdata_reg;
      pslverr_next = 1'b0;
      if (setup) begin
         prdata_next  = {16'h0000, rd_mux};
         pslverr_next = ~hit_any;
      end
      if (wr && hit_ctrl) begin
         // reserved bits are not stored, so sloppy writes cannot reach hidden state
         ctrl_next = uri_pkg::uri_merge_lanes(ctrl_reg, pwdata, pstrb) & uri_pkg::CONTROL_WMASK;
      end
      if (wr && hit_ien) begin
         irq_en_next = uri_pkg::uri_merge_lanes(irq_en_reg, pwdata, pstrb);
      end
      if (wr && hit_mask && pstrb[0]) begin
         mask_next = pwdata[1:0];
      end
      // a write to the event status word clears the event bits written as one
      if (wr && hit_evt && pstrb[0]) begin
         evt_next = evt_reg & ~pwdata[1:0];
      end
      if (rd && hit_data) begin
         flags_next.rx_full = 1'b0;
      end
      if (rx_valid) begin
         rx_data_next       = rx_byte;
         flags_next.rx_full = 1'b1;
         evt_next.rx_full   = 1'b1;
      end
      if (tx_done) begin
         flags_next.tx_full = 1'b0;
         evt_next.tx_full   = 1'b1;
      end
      if (tx_load) begin
         flags_next.tx_full = 1'b1;
      end
      if (!ctrl_reg.enable) begin
         flags_next.tx_full = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg    <= uri_pkg::CONTROL_RESET;
         irq_en_reg  <= uri_pkg::IRQ_EN_RESET;
         mask_reg    <= '0;
         evt_reg     <= '0;
         flags_reg   <= '0;
         rx_data_reg <= '0;
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end else begin
         ctrl_reg    <= ctrl_next;
         irq_en_reg  <= irq_en_next;
         mask_reg    <= mask_next;
         evt_reg     <= evt_next;
         flags_reg   <= flags_next;
         rx_data_reg <= rx_data_next;
         prdata_reg  <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   property p_disable_frees_pins;
      @(posedge pclk) disable iff (!presetn)
         !ctrl_reg.enable |-> (general_io_pin_28_out == gpio_28_value) && (general_io_pin_28_oe == gpio_28_drive)
                              ##1 (!flags_reg.tx_full && !u_tx.done);
   endproperty
   a_disable_frees_pins: assert property (p_disable_frees_pins) else $error("pins not released");

   property p_undivided_rate;
      @(posedge pclk) disable iff (!presetn)
         (!ctrl_reg.prescale && ctrl_reg.baud == 3'h0) |-> bit_div == uri_pkg::DIV_W'(CLK_HZ / 115200);
   endproperty
   a_undivided_rate: assert property (p_undivided_rate) else $error("wrong undivided bit period");

   property p_prescaled_rate;
      @(posedge pclk) disable iff (!presetn)
         ctrl_reg.prescale |-> bit_div == uri_pkg::DIV_W'(div_table[ctrl_reg.baud] * 8);
   endproperty
   a_prescaled_rate: assert property (p_prescaled_rate) else $error("prescaler not eight");

   property p_status_upper_zero;
      @(posedge pclk) disable iff (!presetn)
         (setup && !pwrite && hit_stat) |=> prdata[31:2] == 30'h00000000 && prdata[1:0] == $past(flags_reg);
   endproperty
   a_status_upper_zero: assert property (p_status_upper_zero) else $error("status read wrong");

   property p_rx_clear_on_read;
      @(posedge pclk) disable iff (!presetn)
         (rd && hit_data && !rx_valid) |=> !flags_reg.rx_full ##0 !irq_rx_full;
   endproperty
   a_rx_clear_on_read: assert property (p_rx_clear_on_read) else $error("receive flag not cleared");

   property p_rx_full_irq;
      @(posedge pclk) disable iff (!presetn)
         (rx_valid && serial_ien && !(wr && hit_ien)) |=> flags_reg.rx_full && irq_rx_full;
   endproperty
   a_rx_full_irq: assert property (p_rx_full_irq) else $error("interrupt five missing");

   property p_tx_busy_on_write;
      @(posedge pclk) disable iff (!presetn)
         tx_load |=> flags_reg.tx_full && !irq_tx_empty;
   endproperty
   a_tx_busy_on_write: assert property (p_tx_busy_on_write) else $error("transmit flag not set");

   property p_tx_clear_when_sent;
      @(posedge pclk) disable iff (!presetn)
         (tx_done && !tx_load) |=> !flags_reg.tx_full && (irq_tx_empty == (serial_ien && ctrl_reg.enable));
   endproperty
   a_tx_clear_when_sent: assert property (p_tx_clear_when_sent) else $error("transmit flag stuck");

   property p_data_read_value;
      @(posedge pclk) disable iff (!presetn)
         (setup && !pwrite && hit_data) |=> prdata == {24'h000000, $past(rx_data_reg)};
   endproperty
   a_data_read_value: assert property (p_data_read_value) else $error("data read wrong");

   property p_status_write_ignored;
      @(posedge pclk) disable iff (!presetn)
         (wr && hit_stat && !rx_valid && !tx_done && !tx_load && ctrl_reg.enable) |=> $stable(flags_reg);
   endproperty
   a_status_write_ignored: assert property (p_status_write_ignored) else $error("status write changed flags");

endmodule : uri_top
`default_nettype wire

// file: uri_link_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side serial device: decodes the transmit pin, drives the receive pin
module uri_link_model (
   input  wire logic        pclk,    // block clock
   input  wire logic        txd,     // transmit pin
   input  wire logic [15:0] bit_cyc, // clocks per bit
   output logic             rxd,     // receive pin
   output logic             got,     // byte decoded, pulse
   output logic [7:0]       got_byte // decoded byte
);
   int i;
   initial begin
      rxd = 1'b1;
      got = 1'b0;
      got_byte = 8'h00;
   end
   // sample mid-bit so small edge drift still decodes
   always begin
      @(negedge txd);
      repeat (bit_cyc / 2) @(posedge pclk);
      for (i = 0; i < 8; i++) begin
         repeat (bit_cyc) @(posedge pclk);
         got_byte[i] <= txd;
      end
      repeat (bit_cyc) @(posedge pclk);
      got <= txd;
      @(posedge pclk);
      got <= 1'b0;
   end
   // one frame, line back high after the stop bit
   task automatic send(input logic [7:0] b);
      int k;
      rxd <= 1'b0;
      for (k = 0; k < 9; k++) begin
         repeat (bit_cyc) @(posedge pclk);
         rxd <= (k < 8) ? b[k] : 1'b1;
      end
      repeat (bit_cyc) @(posedge pclk);
   endtask : send
endmodule : uri_link_model
`default_nettype wire

// file: uri_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uri_top_tb;
   logic        pclk, presetn, psel, penable, pwrite, gdv, gdr, pready, pslverr, irq, irq_rx, irq_tx;
   logic        p28, p28_oe, rxd, got;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  got_byte, b;
   logic [15:0] bc;
   logic [32:0] q_rd[$];
   logic [7:0]  q_tx[$];
   int          n_errors, checked, t;
   uri_top #(.CLK_HZ(1152000)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .irq_rx_full(irq_rx), .irq_tx_empty(irq_tx), .gpio_28_value(gdv),
      .gpio_28_drive(gdr), .general_io_pin_28_out(p28), .general_io_pin_28_oe(p28_oe),
      .general_io_pin_27_in(rxd));
   uri_link_model link (.pclk(pclk), .txd(p28), .bit_cyc(bc), .rxd(rxd), .got(got), .got_byte(got_byte));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic stop_test();
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : stop_test
   // apb transfer, called just after a rising edge
   task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (t = 0; pready !== 1'b1; t++) begin
         if (t > 50) begin
            n_errors++;
            stop_test();
         end
         @(posedge pclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [15:0] idx, input logic [32:0] e);
      q_rd.push_back(e);
      apb(1'b0, idx, 16'h0000);
   endtask : rd
   // results are compared as they appear at the outputs
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && q_rd.size() > 0) chk("read", q_rd.pop_front(), {pslverr, prdata});
      if (got === 1'b1 && q_tx.size() > 0) chk("tx byte", q_tx.pop_front(), {25'h0, got_byte});
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, gdr} = '0;
      gdv = 1'b1;
      bc = 16'd10;
      b = 8'($urandom(32'hA2DD));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(16'hC0E0, 33'h0_0000_0007);
      rd(16'hC0E2, 33'h0);
      rd(16'hC0F0, 33'h1_0000_0000);
      apb(1'b1, 16'hC112, 16'h0003);
      $display("test reset done");
      // code 0 undivided, then code 1 divided by eight
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, 16'hC0E0, s ? 16'h0013 : 16'h0001);
         bc <= s ? 16'd160 : 16'd10;
         apb(1'b1, 16'hC00E, 16'h0010);
         chk("tx irq", 33'h1, {32'h0, irq_tx});
         b = 8'($urandom);
         q_tx.push_back(b);
         apb(1'b1, 16'hC0E4, {8'h00, b});
         rd(16'hC0E2, 33'h1);
         chk("tx irq", 33'h0, {32'h0, irq_tx});
         for (t = 0; q_tx.size() > 0; t++) begin
            if (t > 3000) begin
               n_errors++;
               stop_test();
            end
            @(posedge pclk);
         end
         repeat (bc) @(posedge pclk); // stop bit ends half a bit after its sample
         rd(16'hC0E2, 33'h0);
         chk("irq", 33'h1, {32'h0, irq});
         apb(1'b1, 16'hC110, 16'h0003);
         chk("irq", 33'h0, {32'h0, irq});
         $display("test tx %0d done", s);
      end
      // receive with the event masked
      apb(1'b1, 16'hC112, 16'h0000);
      b = 8'($urandom);
      link.send(b);
      repeat (4) @(posedge pclk);
      chk("rx irq", 33'h1, {32'h0, irq_rx});
      chk("masked irq", 33'h0, {32'h0, irq});
      rd(16'hC0E2, 33'h2);
      apb(1'b1, 16'hC0E2, 16'h0000);
      rd(16'hC0E2, 33'h2);
      rd(16'hC0E4, {25'h0, b});
      rd(16'hC0E2, 33'h0);
      chk("rx irq", 33'h0, {32'h0, irq_rx});
      $display("test rx done");
      // general io asks for the opposite of what the serial side would show
      gdr <= 1'b0;
      gdv <= 1'b0;
      apb(1'b1, 16'hC0E0, 16'h0000);
      chk("pin oe", {32'h0, gdr}, {32'h0, p28_oe});
      chk("pin out", 33'h0, {32'h0, p28});
      repeat (2) @(posedge pclk);
      $display("test disable done");
      stop_test();
   end
endmodule : uri_top_tb
`default_nettype wire
